// *** hw/serirq_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - leave wire undriven outside cycles
// - time cycles from bus clock
// - start frame is four to eight lows
// - continuous mode: only host starts cycle
// - reset enters continuous mode, await host
// - quiet request: one low clock, then release
// - host extends request low three-seven clocks
// - host drives high one clock, releases
// - no start frame during active cycle
// - count irq frames on rising edges
// - frame is sample, recovery, turn-around
// - sample phase low when irq active
// - recovery phase high after driving low
// - turn-around phase always released
// - report only lines 3,4,5,7,9,10,11
// - frame n sampled 3n-1 clocks after start
// - only host ends cycle with stop
// - stop length two quiet, three continuous
module serirq_dev
(
    input  wire logic                          clock,
    input  wire logic                          sys_rst,
    serirq_if.dev                              link,
    input  wire logic [serirq_pkg::NUM_IRQ-1:0] irq_level,   // active-high irq sources
    input  wire logic [serirq_pkg::NUM_IRQ-1:0] irq_enable,  // per-line report enable
    output logic                               quiet_mode,  // next cycle is quiet
    output logic                               cycle_active // cycle in progress
);
    import serirq_pkg::*;

    // pin synchroniser: three flops, change counts when 2nd and 3rd agree
    logic       s1_r, s2_r, s3_r;
    logic       wire_r;           // filtered wire level
    logic       wire_prev_r;      // previous filtered level
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            wire_r <= 1'b1;
            wire_prev_r <= 1'b1;
        end else begin
            s1_r <= link.wire_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                wire_r <= s3_r;
            end
            wire_prev_r <= wire_r;
        end
    end

    logic rise;  // end of a low period
    assign rise = wire_r && !wire_prev_r;

    link_state_t state_r;
    logic [3:0]  low_cnt_r;      // length of current low period
    logic [7:0]  clk_cnt_r;      // clocks since end of start frame
    logic [15:0] reported_r;     // levels reported in last cycle
    logic [15:0] masked;         // lines we may report
    logic [15:0] pending_r;      // snapshot taken at cycle start
    logic        drive_low_r;    // sampled low in this frame
    logic        dev_out_r;
    logic        dev_oe_r;
    logic        quiet_r;

    assign masked = irq_level & irq_enable & IRQ_SUPPORTED;

    // measure low periods on the filtered wire
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_r <= 4'h0;
        end else if (!wire_r) begin
            if (low_cnt_r != LOW_CNT_MAX) begin
                low_cnt_r <= low_cnt_r + 4'h1;
            end
        end else begin
            low_cnt_r <= 4'h0;
        end
    end

    // frame sequencing, timed only from the bus clock
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r   <= ST_IDLE;
            clk_cnt_r <= 8'h00;
            quiet_r   <= 1'b0;
            pending_r <= 16'h0000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // continuous mode: wait for host start frame
                    if (!wire_r) begin
                        state_r <= ST_START;
                    end else if (quiet_r && (masked != reported_r)) begin
                        state_r <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    // one clock pulse issued; now follow host low
                    state_r <= ST_START;
                end
                ST_START: begin
                    // start frame ends on rising edge, length 4..8
                    if (rise) begin
                        if (low_cnt_r >= 4'(START_MIN_CLKS)
                                && low_cnt_r <= 4'(START_MAX_CLKS)) begin
                            state_r   <= ST_FRAMES;
                            // filter and edge detect cost these clocks; starting
                            // the count there puts slots on the wire at 3n-1
                            clk_cnt_r <= FRAME_ALIGN;
                            pending_r <= masked;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_FRAMES: begin
                    // count frames on rising clock edges
                    clk_cnt_r <= clk_cnt_r + 8'h01;
                    if (clk_cnt_r == LAST_CLK) begin
                        state_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // host-only stop frame, length picks next mode
                    if (rise) begin
                        if (low_cnt_r == 4'(STOP_QUIET)) begin
                            quiet_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end else if (low_cnt_r == 4'(STOP_CONT)) begin
                            quiet_r <= 1'b0;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // frame slot lookup: phase and which isa line this clock belongs to
    logic [7:0] rel;      // clocks past first sample
    logic [1:0] phase;    // 0 sample, 1 recovery, 2 turn-around
    logic [5:0] frame_ix; // frame index, 0 = frame 1
    logic       my_slot;  // this frame carries a supported line
    logic [3:0] line;     // isa line number of frame
    always_comb begin
        rel      = clk_cnt_r - FIRST_SAMPLE;
        phase    = 2'(rel % 8'(FRAME_CLKS));
        frame_ix = 6'(rel / 8'(FRAME_CLKS));
        // frame 3 carries smi, frames 4+ carry irq3 onward
        line     = (frame_ix >= 6'd3) ? 4'(frame_ix) : 4'h0;
        my_slot  = (clk_cnt_r >= FIRST_SAMPLE) && (frame_ix >= 6'd3)
                   && (frame_ix < 6'(NUM_IRQ)) && IRQ_SUPPORTED[line];
    end

    // remember what was reported in the last cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reported_r <= 16'h0000;
        end else if (state_r == ST_STOP && rise) begin
            reported_r <= pending_r;
        end
    end

    // wire drive: request pulse and per-frame sample/recovery
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dev_out_r   <= 1'b1;
            dev_oe_r    <= 1'b0;
            drive_low_r <= 1'b0;
        end else begin
            dev_out_r <= 1'b1;
            dev_oe_r  <= 1'b0;
            if (state_r == ST_IDLE && wire_r && quiet_r
                    && (masked != reported_r)) begin
                // one low clock, released next clock
                dev_out_r <= 1'b0;
                dev_oe_r  <= 1'b1;
            end else if (state_r == ST_FRAMES && my_slot) begin
                if (phase == 2'd0 && pending_r[line]) begin
                    dev_out_r   <= 1'b0;
                    dev_oe_r    <= 1'b1;
                    drive_low_r <= 1'b1;
                end else if (phase == 2'd1 && drive_low_r) begin
                    dev_out_r   <= 1'b1;
                    dev_oe_r    <= 1'b1;
                    drive_low_r <= 1'b0;
                end
            end
        end
    end

    // status outputs
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_mode   <= 1'b0;
            cycle_active <= 1'b0;
        end else begin
            quiet_mode   <= quiet_r;
            cycle_active <= (state_r != ST_IDLE) && (state_r != ST_REQ);
        end
    end

    assign link.dev_out = dev_out_r;
    assign link.dev_oe  = dev_oe_r;
endmodule
`default_nettype wire

// *** hw/serirq_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// host controller end of the serial interrupt wire
module serirq_host
#(
    parameter int unsigned START_LOW = 6  // start frame low clocks, 4..8
)(
    input  wire logic                           clock,
    input  wire logic                           sys_rst,
    serirq_if.host                              link,
    input  wire logic                           run_cycle,  // begin continuous cycle
    input  wire logic                           want_quiet, // end with quiet stop
    output logic [serirq_pkg::NUM_IRQ-1:0]      irq_seen,   // latched irq levels
    output logic                                done        // one-cycle pulse
);
    import serirq_pkg::*;

    // three-flop pin delay; no two-sample vote, since a slot low
    // lasts one clock and a vote would swallow every irq frame
    logic s1_r, s2_r, s3_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
        end else begin
            s1_r <= link.wire_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    host_state_t st_r;
    logic [7:0]  cnt_r;      // phase counter
    logic        quiet_r;    // current mode
    logic        out_r, oe_r;
    logic [15:0] seen_r;

    // host sequencer: start, high, slots, stop
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r    <= H_IDLE;
            cnt_r   <= 8'h00;
            quiet_r <= 1'b0;          // continuous after reset
            out_r   <= 1'b1;
            oe_r    <= 1'b0;          // released when idle
            seen_r  <= 16'h0000;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_r)
                H_IDLE: begin
                    oe_r <= 1'b0;
                    // continuous start by host, quiet start on device pulse
                    // the request is one clock and must be taken over on the
                    // next, so the wire (on our own clock) is read as it is
                    if ((!quiet_r && run_cycle) || (quiet_r && !link.wire_in)) begin
                        st_r  <= H_START;
                        out_r <= 1'b0;
                        oe_r  <= 1'b1;
                        cnt_r <= quiet_r ? 8'h01 : 8'h00;
                    end
                end
                H_START: begin
                    // hold low so total low is START_LOW
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'(START_LOW - 1)) begin
                        out_r <= 1'b1;  // drive high one clock
                        st_r  <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    oe_r  <= 1'b0;
                    cnt_r <= 8'h00;
                    st_r  <= H_SLOTS;
                end
                H_SLOTS: begin
                    // sample each frame; frame 1 is one clock in, the delay chain costs three more
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r >= 8'h04 && (cnt_r - 8'h04) % 8'(FRAME_CLKS) == 8'h00
                            && (cnt_r - 8'h04) / 8'(FRAME_CLKS) >= 8'h03
                            && (cnt_r - 8'h04) / 8'(FRAME_CLKS) < 8'(NUM_IRQ)) begin
                        seen_r[4'((cnt_r - 8'h04) / 8'(FRAME_CLKS))] <= !s3_r;
                    end
                    if (cnt_r == LAST_CLK + 8'h04) begin
                        st_r  <= H_STOP;
                        cnt_r <= 8'h00;
                        out_r <= 1'b0;
                        oe_r  <= 1'b1;   // only host ends the cycle
                    end
                end
                H_STOP: begin
                    // stop low 2 for quiet, 3 for continuous
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'(want_quiet ? STOP_QUIET - 1 : STOP_CONT - 1)) begin
                        out_r   <= 1'b1;
                        quiet_r <= want_quiet;
                        st_r    <= H_GAP;
                        cnt_r   <= 8'h00;
                    end
                end
                H_GAP: begin
                    // high one clock, then release; settle before next start
                    oe_r  <= 1'b0;
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'h05) begin
                        st_r <= H_IDLE;
                        done <= 1'b1;
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_seen <= 16'h0000;
        end else if (st_r == H_GAP && cnt_r == 8'h05) begin
            irq_seen <= seen_r;
        end
    end

    assign link.host_out = out_r;
    assign link.host_oe  = oe_r;
endmodule
`default_nettype wire

// *** hw/serirq_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// shared open-drain style interrupt wire between host and peripherals
interface serirq_if;
    logic dev_out;   // level the peripheral drives
    logic dev_oe;    // peripheral drives the wire
    logic host_out;  // level the host drives
    logic host_oe;   // host drives the wire
    logic wire_in;   // resolved wire level, resolved by the testbench
    modport dev  (output dev_out, output dev_oe, input wire_in);
    modport host (output host_out, output host_oe, input wire_in);
endinterface
`default_nettype wire

// *** hw/serirq_pkg.sv ***
`default_nettype none
package serirq_pkg;
    // frame geometry
    localparam int unsigned FRAME_CLKS     = 3;   // sample, recovery, turn-around
    localparam int unsigned FRAME_COUNT    = 32;  // frames per cycle incl. unassigned
    localparam int unsigned START_MIN_CLKS = 4;   // shortest start frame low time
    localparam int unsigned START_MAX_CLKS = 8;   // longest start frame low time
    localparam int unsigned STOP_QUIET     = 2;   // stop low clocks selecting quiet
    localparam int unsigned STOP_CONT      = 3;   // stop low clocks selecting continuous
    localparam int unsigned NUM_IRQ        = 16;  // isa-style irq lines carried
    // lines the peripheral may report: 3,4,5,7,9,10,11
    localparam logic [15:0] IRQ_SUPPORTED  = 16'h0eb8;
    // first sample clock after start frame end (frame n sampled 3n-1)
    localparam logic [7:0]  FIRST_SAMPLE   = 8'h02;
    localparam logic [7:0]  LAST_CLK       = 8'h5f;  // 95 clocks past start
    // clocks past start already gone when the filtered start edge is acted on
    localparam logic [7:0]  FRAME_ALIGN    = 8'h06;
    localparam logic [3:0]  LOW_CNT_MAX    = 4'hf;
    // frame number for isa irq k (irq0..2 frames 1..3, irq3 frame 4)
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,  // wire released, link idle
        ST_START  = 3'b001,  // start frame low seen
        ST_FRAMES = 3'b010,  // counting irq frames
        ST_STOP   = 3'b011,  // waiting for / measuring stop frame
        ST_REQ    = 3'b100   // quiet-mode request pulse
    } link_state_t;
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_START = 3'b001,
        H_HIGH  = 3'b010,
        H_SLOTS = 3'b011,
        H_STOP  = 3'b100,
        H_GAP   = 3'b101
    } host_state_t;
endpackage
`default_nettype wire

// *** tb/serirq_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the shared interrupt wire between both ends
module serirq_assertions (
    input wire logic clock,     // bus clock
    input wire logic sys_rst,   // async reset, high
    input wire logic dev_out,   // peripheral drive level
    input wire logic dev_oe,    // peripheral drives
    input wire logic host_out,  // host drive level
    input wire logic host_oe,   // host drives
    input wire logic wire_in    // resolved level
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    logic       dlo;    // peripheral pulls low
    logic       dhi;    // peripheral drives high
    logic       hlo;    // host pulls low
    logic       hhi;    // host drives high
    logic [3:0] run_r;  // host low run length
    assign dlo = dev_oe && !dev_out;
    assign dhi = dev_oe && dev_out;
    assign hlo = host_oe && !host_out;
    assign hhi = host_oe && host_out;

    // counts consecutive host low clocks, saturating
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            run_r <= 4'h0;
        end else if (hlo && run_r != 4'hf) begin
            run_r <= run_r + 4'h1;
        end else if (!hlo) begin
            run_r <= 4'h0;
        end
    end

    // host lets go of a low drive
    sequence host_low_end;
        hlo ##1 !hlo;
    endsequence
    // peripheral low then quiet for a frame remainder
    sequence dev_frame_rest;
        !dlo [*2];
    endsequence

    a_host_low_len: assert property (host_low_end |-> run_r >= 4'h2 && run_r <= 4'h8)
        else $error("host low run outside two to eight clocks");
    a_host_low_high: assert property (host_low_end |-> hhi)
        else $error("host low not followed by one high clock");
    a_host_high_release: assert property (hhi |=> !host_oe)
        else $error("host kept driving after its high clock");
    a_dev_frame_gap: assert property (dlo |=> dev_frame_rest)
        else $error("peripheral low twice within one frame");
    a_dev_turn_release: assert property (dhi |=> !dev_oe)
        else $error("peripheral drove in turn-around");
    a_dev_recover_high: assert property (dhi |-> $past(dlo))
        else $error("peripheral high without a low before it");
    a_one_driver: assert property (!(dev_oe && host_oe))
        else $error("both ends drive the wire together");
    a_dev_after_host: assert property (hhi |=> !dev_oe)
        else $error("peripheral drove right after host high");
    a_dev_low_idle: assert property (dlo |-> $past(wire_in))
        else $error("peripheral pulled low right after a low clock");
endmodule
`default_nettype wire

// *** tb/tb_serial_irq_peripheral.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_serial_irq_peripheral;
    import serirq_pkg::*;
    logic        clock;            // 200 MHz
    logic        sys_rst;          // async reset
    logic        run_cycle;        // host start request
    logic        want_quiet;       // quiet stop select
    logic        quiet_mode;       // peripheral mode flag
    logic        cycle_active;     // peripheral busy
    logic        done;             // host end pulse
    logic [15:0] irq_level;        // interrupt sources
    logic [15:0] irq_enable;       // report enables
    logic [15:0] irq_seen;         // host view
    int          num_errors;       // mismatches
    int          samples_checked;  // comparisons
    int          dev_lows;         // peripheral low clocks
    int          run_len;          // current wire low run
    int          start_len;        // previous long low run
    int          stop_len;         // latest long low run

    serirq_if link ();
    // pull-up unless an end pulls low
    assign link.wire_in = ((link.dev_oe && !link.dev_out) ||
                           (link.host_oe && !link.host_out)) ? 1'b0 : 1'b1;

    serirq_dev i_serirq_dev (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .link         (link.dev),
        .irq_level    (irq_level),
        .irq_enable   (irq_enable),
        .quiet_mode   (quiet_mode),
        .cycle_active (cycle_active)
    );
    serirq_host #(.START_LOW(6)) i_serirq_host (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .link       (link.host),
        .run_cycle  (run_cycle),
        .want_quiet (want_quiet),
        .irq_seen   (irq_seen),
        .done       (done)
    );
    serirq_assertions i_serirq_assertions (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .dev_out  (link.dev_out),
        .dev_oe   (link.dev_oe),
        .host_out (link.host_out),
        .host_oe  (link.host_oe),
        .wire_in  (link.wire_in)
    );

    // clock source
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // measures wire low runs and peripheral low clocks
    always @(posedge clock) begin
        if (link.dev_oe && !link.dev_out) dev_lows++;
        if (!link.wire_in) begin
            run_len++;
        end else begin
            if (run_len > 1) begin
                start_len = stop_len;
                stop_len = run_len;
            end
            run_len = 0;
        end
    end

    // single compare for every result
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // waits for the host end pulse, bounded
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk("done", 16'h1, {15'h0, done});
    endtask

    // sets sources, optionally starts a cycle, waits for its end
    task automatic serial_cycle(input logic go, input logic quiet, input logic [15:0] lvl,
                                input logic [15:0] en);
        irq_level = lvl;
        irq_enable = en;
        want_quiet = quiet;
        dev_lows = 0;
        run_cycle = go;
        @(negedge clock);
        run_cycle = 1'b0;
        wait_done();
        @(negedge clock);
    endtask

    // reads back host view and peripheral flags
    task automatic read_state(input logic [15:0] seen, input logic quiet);
        chk("irq_seen", seen, irq_seen);
        chk("quiet_mode", {15'h0, quiet}, {15'h0, quiet_mode});
        chk("cycle_active", 16'h0, {15'h0, cycle_active});
    endtask

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, well past the expected run
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end

    // main sequence, inputs change on falling edges
    initial begin
        sys_rst = 1'b1;
        run_cycle = 1'b0;
        want_quiet = 1'b0;
        irq_level = 16'h0;
        irq_enable = 16'h0;
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        read_state(16'h0, 1'b0);
        chk("dev_oe", 16'h0, {15'h0, link.dev_oe});
        // every line raised: only the supported ones appear
        serial_cycle(1'b1, 1'b0, 16'hffff, 16'hffff);
        read_state(IRQ_SUPPORTED, 1'b0);
        chk("dev lows", 16'd7, 16'(dev_lows));
        chk("start low", 16'd6, 16'(start_len));
        chk("stop low", 16'd3, 16'(stop_len));
        // continuous mode: a level change alone starts nothing
        irq_level = 16'h0008;
        dev_lows = 0;
        repeat (200) @(negedge clock);
        chk("idle lows", 16'h0, 16'(dev_lows));
        // masked line, later slots, quiet stop
        serial_cycle(1'b1, 1'b1, 16'h0a28, 16'hffdf);
        read_state(16'h0a08, 1'b1);
        chk("stop low", 16'd2, 16'(stop_len));
        // quiet mode: changed level makes the peripheral ask
        serial_cycle(1'b0, 1'b0, 16'h0694, 16'hffff);
        read_state(16'h0690, 1'b0);
        chk("dev lows", 16'd5, 16'(dev_lows));
        chk("start low", 16'd6, 16'(start_len));
        end_of_test();
    end
endmodule
`default_nettype wire
